// File: sszh_pkg.sv
package sszh_pkg;
	localparam int SPD_W = 16;
	localparam int DO_N = 4;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_HOLD_LIM   = 8'h04;
	localparam logic [7:0] OFS_ROT_LIM    = 8'h08;
	localparam logic [7:0] OFS_STILL_LIM  = 8'h0C;
	localparam logic [7:0] OFS_MATCH_WIN  = 8'h10;
	localparam logic [7:0] OFS_REACH_LIM  = 8'h14;
	localparam logic [7:0] OFS_DO_FUNC    = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1C;
	// reset values and ranges, rpm
	localparam logic [1:0]  RST_HOLD_MODE = 2'h0;
	localparam logic [12:0] RST_HOLD_LIM  = 13'h0014;
	localparam logic [12:0] MAX_HOLD_LIM  = 13'h03E8;
	localparam logic [12:0] RST_ROT_LIM   = 13'h0014;
	localparam logic [12:0] MAX_ROT_LIM   = 13'h03E8;
	localparam logic [12:0] RST_STILL_LIM = 13'h000A;
	localparam logic [12:0] MAX_STILL_LIM = 13'h1770;
	localparam logic [12:0] RST_MATCH_WIN = 13'h000A;
	localparam logic [12:0] MAX_MATCH_WIN = 13'h0064;
	localparam logic [12:0] RST_REACH_LIM = 13'h0064;
	localparam logic [12:0] MIN_REACH_LIM = 13'h000A;
	localparam logic [12:0] MAX_REACH_LIM = 13'h1770;
	// output terminal function codes
	localparam logic [7:0] FN_ROTATING = 8'h84;
	localparam logic [7:0] FN_STILL    = 8'h85;
	localparam logic [7:0] FN_MATCH    = 8'h88;
	localparam logic [7:0] FN_REACHED  = 8'h89;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {HM_FORCE, HM_LOCK_ACT, HM_LOCK_CMD, HM_OFF} sszh_hmode_t;
	typedef struct packed {
		logic reached;
		logic match;
		logic still;
		logic rotating;
	} sszh_flags_t;
	typedef struct packed {
		logic force_zero;
		logic lock_pos;
	} sszh_hold_t;
endpackage

// File: sszh_top.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
// Notes on behaviour
// RQ1 - hold active and small command: lock position, ignore speed command
// RQ2 - command magnitude above hold limit: leave lock, follow command again
// RQ3 - mode 0 forces zero speed while hold active; mode 3 ignores hold
// RQ4 - mode 1: force zero, lock once actual speed below hold limit
// RQ5 - mode 2: force zero and lock only while command below hold limit
// RQ6 - hold limit 0..1000 rpm resets to 20; hold mode resets to 0
// RQ7 - rotating flag set when actual magnitude at or above rotating limit
// RQ8 - rotating limit 0..1000 rpm, reset 20
// RQ9 - standstill flag set when actual magnitude below standstill limit
// RQ10 - standstill limit 0..6000 rpm, reset 10
// RQ11 - match flag set while |actual - command| within match window
// RQ12 - match window 0..100 rpm, reset 10
// RQ13 - reached flag set when actual magnitude exceeds reached limit
// RQ14 - reached limit 10..6000 rpm, reset 100
// RQ15 - flag reaches a terminal only when its function code is assigned
// RQ16 - speeds signed rpm, magnitudes compared, new settings used next cycle
module sszh_top #(
	parameter int SPD_W = sszh_pkg::SPD_W,
	parameter int DO_N  = sszh_pkg::DO_N
) (
	input  wire logic                    aclk,          // 40 MHz system clock
	input  wire logic                    aresetn,       // synchronous reset, active low
	input  wire logic [7:0]              s_axi_awaddr,  // write address
	input  wire logic                    s_axi_awvalid, // write address valid
	output logic                         s_axi_awready, // write address ready
	input  wire logic [31:0]             s_axi_wdata,   // write data
	input  wire logic [3:0]              s_axi_wstrb,   // write strobes
	input  wire logic                    s_axi_wvalid,  // write data valid
	output logic                         s_axi_wready,  // write data ready
	output logic [1:0]                   s_axi_bresp,   // write response
	output logic                         s_axi_bvalid,  // write response valid
	input  wire logic                    s_axi_bready,  // write response ready
	input  wire logic [7:0]              s_axi_araddr,  // read address
	input  wire logic                    s_axi_arvalid, // read address valid
	output logic                         s_axi_arready, // read address ready
	output logic [31:0]                  s_axi_rdata,   // read data
	output logic [1:0]                   s_axi_rresp,   // read response
	output logic                         s_axi_rvalid,  // read data valid
	input  wire logic                    s_axi_rready,  // read data ready
	input  wire logic                    zero_hold_input, // hold pin, asynchronous
	input  wire logic signed [SPD_W-1:0] speed_cmd,     // speed command, rpm
	input  wire logic signed [SPD_W-1:0] speed_act,     // filtered actual speed, rpm
	output logic                         force_zero,    // speed command replaced by zero
	output logic                         lock_pos,      // position lock request
	output sszh_pkg::sszh_flags_t        flags,         // raw status flags
	output logic [DO_N-1:0]              do_out         // digital output terminals
);
	localparam int LW = 13;

	// settings
	logic [1:0]      hold_mode;
	logic [LW-1:0]   hold_lim, rot_lim, still_lim, match_win, reach_lim;
	logic [DO_N-1:0][7:0] do_func;

	// hold pin synchroniser
	logic hold_s1, hold_s2;
	always_ff @(posedge aclk) begin
		hold_s1 <= zero_hold_input;
		hold_s2 <= hold_s1;
	end

	// magnitudes, widened by one bit so the most negative value is safe
	wire logic [SPD_W:0] cmd_mag = speed_cmd[SPD_W-1] ?
		(SPD_W+1)'(-$signed({speed_cmd[SPD_W-1], speed_cmd})) : {1'b0, speed_cmd}; // RQ16
	wire logic [SPD_W:0] act_mag = speed_act[SPD_W-1] ?
		(SPD_W+1)'(-$signed({speed_act[SPD_W-1], speed_act})) : {1'b0, speed_act}; // RQ16
	wire logic signed [SPD_W:0] diff = $signed({speed_act[SPD_W-1], speed_act})
		- $signed({speed_cmd[SPD_W-1], speed_cmd});
	wire logic [SPD_W:0] diff_mag = diff[SPD_W] ? (SPD_W+1)'(-diff) : diff;
	wire logic [SPD_W:0] hold_w  = (SPD_W+1)'(hold_lim);
	wire logic cmd_small = cmd_mag < hold_w;
	wire logic act_small = act_mag < hold_w;

	// hold decision
	logic next_force, next_lock;
	always_comb begin
		next_force = 1'b0;
		next_lock  = 1'b0;
		case (sszh_pkg::sszh_hmode_t'(hold_mode))
			sszh_pkg::HM_FORCE: begin
				next_force = hold_s2; // RQ3
			end
			sszh_pkg::HM_LOCK_ACT: begin
				next_force = hold_s2;             // RQ4
				next_lock  = hold_s2 & act_small; // RQ4
			end
			sszh_pkg::HM_LOCK_CMD: begin
				// lock drops once the command magnitude reaches the hold limit
				next_force = hold_s2 & cmd_small; // RQ1 RQ2 RQ5
				next_lock  = hold_s2 & cmd_small; // RQ1 RQ2 RQ5
			end
			sszh_pkg::HM_OFF: begin
				next_force = 1'b0; // RQ3
			end
			default: begin
				next_force = 1'b0;
			end
		endcase
	end

	sszh_pkg::sszh_flags_t next_flags;
	always_comb begin
		next_flags.rotating = act_mag >= (SPD_W+1)'(rot_lim);    // RQ7
		next_flags.still    = act_mag <  (SPD_W+1)'(still_lim);  // RQ9
		next_flags.match    = diff_mag <= (SPD_W+1)'(match_win); // RQ11
		next_flags.reached  = act_mag >  (SPD_W+1)'(reach_lim);  // RQ13
	end

	// terminal routing: one selector per output
	logic [DO_N-1:0] next_do;
	genvar gi;
	generate
		for (gi = 0; gi < DO_N; gi++) begin : g_do
			assign next_do[gi] =
				(do_func[gi] == sszh_pkg::FN_ROTATING) ? next_flags.rotating : // RQ15
				(do_func[gi] == sszh_pkg::FN_STILL)    ? next_flags.still :
				(do_func[gi] == sszh_pkg::FN_MATCH)    ? next_flags.match :
				(do_func[gi] == sszh_pkg::FN_REACHED)  ? next_flags.reached : 1'b0;
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_zero <= 1'b0;
			lock_pos   <= 1'b0;
			flags      <= '0;
			do_out     <= '0;
		end else begin
			force_zero <= next_force;
			lock_pos   <= next_lock;
			flags      <= next_flags;
			do_out     <= next_do;
		end
	end

	// ---- AXI4-Lite slave: takes aw and w in either order ----
	logic       aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	wire logic aw_now = aw_held || s_axi_awvalid;
	wire logic w_now  = w_held || s_axi_wvalid;
	wire logic [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
	wire logic [31:0] wd = w_held ? w_data : s_axi_wdata;
	wire logic [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
	wire logic do_wr = aw_now && w_now && !s_axi_bvalid;
	// full-word fields are taken only with both low lanes strobed
	wire logic lanes = ws[0] && ws[1];
	wire logic [LW-1:0] wv = wd[LW-1:0];
	wire logic hi_zero = wd[31:LW] == '0;
	wire logic wr_ctrl  = wa == sszh_pkg::OFS_CTRL;
	wire logic wr_hold  = wa == sszh_pkg::OFS_HOLD_LIM;
	wire logic wr_rot   = wa == sszh_pkg::OFS_ROT_LIM;
	wire logic wr_still = wa == sszh_pkg::OFS_STILL_LIM;
	wire logic wr_match = wa == sszh_pkg::OFS_MATCH_WIN;
	wire logic wr_reach = wa == sszh_pkg::OFS_REACH_LIM;
	wire logic wr_func  = wa == sszh_pkg::OFS_DO_FUNC;
	// out-of-range settings are refused with SLVERR and leave the old value
	wire logic ok_hold  = hi_zero && wv <= sszh_pkg::MAX_HOLD_LIM;  // RQ6
	wire logic ok_rot   = hi_zero && wv <= sszh_pkg::MAX_ROT_LIM;   // RQ8
	wire logic ok_still = hi_zero && wv <= sszh_pkg::MAX_STILL_LIM; // RQ10
	wire logic ok_match = hi_zero && wv <= sszh_pkg::MAX_MATCH_WIN; // RQ12
	wire logic ok_reach = hi_zero && wv >= sszh_pkg::MIN_REACH_LIM
		&& wv <= sszh_pkg::MAX_REACH_LIM; // RQ14
	wire logic wr_ok = (wr_ctrl && wd[31:2] == '0) || wr_func
		|| (wr_hold && ok_hold) || (wr_rot && ok_rot) || (wr_still && ok_still)
		|| (wr_match && ok_match) || (wr_reach && ok_reach);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= sszh_pkg::RESP_OKAY;
		end else begin
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? sszh_pkg::RESP_OKAY : sszh_pkg::RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// settings are loaded on the same edge that raises the write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_mode <= sszh_pkg::RST_HOLD_MODE; // RQ6
			hold_lim  <= sszh_pkg::RST_HOLD_LIM;  // RQ6
			rot_lim   <= sszh_pkg::RST_ROT_LIM;   // RQ8
			still_lim <= sszh_pkg::RST_STILL_LIM; // RQ10
			match_win <= sszh_pkg::RST_MATCH_WIN; // RQ12
			reach_lim <= sszh_pkg::RST_REACH_LIM; // RQ14
			do_func   <= '0;
		end else if (do_wr && wr_ok) begin
			if (wr_ctrl && ws[0])
				hold_mode <= wd[1:0];
			if (wr_hold && lanes)
				hold_lim <= wv;
			if (wr_rot && lanes)
				rot_lim <= wv;
			if (wr_still && lanes)
				still_lim <= wv;
			if (wr_match && lanes)
				match_win <= wv;
			if (wr_reach && lanes)
				reach_lim <= wv;
			if (wr_func) begin
				for (int i = 0; i < DO_N; i++)
					if (ws[i])
						do_func[i] <= wd[i*8 +: 8];
			end
		end
	end

	// read channel: one cycle latency
	logic [31:0] rd_mux;
	wire logic [7:0] ra = s_axi_araddr;
	wire logic rd_hit = ra <= sszh_pkg::OFS_STATUS && ra[1:0] == 2'h0;
	always_comb begin
		case (ra)
			sszh_pkg::OFS_CTRL:      rd_mux = {30'h0, hold_mode};
			sszh_pkg::OFS_HOLD_LIM:  rd_mux = {19'h0, hold_lim};
			sszh_pkg::OFS_ROT_LIM:   rd_mux = {19'h0, rot_lim};
			sszh_pkg::OFS_STILL_LIM: rd_mux = {19'h0, still_lim};
			sszh_pkg::OFS_MATCH_WIN: rd_mux = {19'h0, match_win};
			sszh_pkg::OFS_REACH_LIM: rd_mux = {19'h0, reach_lim};
			sszh_pkg::OFS_DO_FUNC:   rd_mux = do_func;
			sszh_pkg::OFS_STATUS:    rd_mux = {24'h0, force_zero, lock_pos, hold_s2,
				1'b0, flags};
			default:                 rd_mux = 32'h0000_0000;
		endcase
	end
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= sszh_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? sszh_pkg::RESP_OKAY : sszh_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---- checks ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	hold_mode_lock_a: assert property ( // RQ5
		aresetn && hold_mode == 2'h2 && hold_s2 && cmd_small |=> lock_pos && force_zero)
		else $error("mode 2 hold did not lock");
	hold_release_a: assert property ( // RQ2
		hold_mode == 2'h2 && !cmd_small |=> !lock_pos)
		else $error("lock kept with large command");
	mode_off_a: assert property ( // RQ3
		hold_mode == 2'h3 |=> !force_zero && !lock_pos)
		else $error("hold acted in mode 3");
	mode_force_a: assert property ( // RQ3
		aresetn && hold_mode == 2'h0 |=> force_zero == $past(hold_s2) && !lock_pos)
		else $error("mode 0 force mismatch");
	act_lock_a: assert property ( // RQ4
		aresetn && hold_mode == 2'h1 && hold_s2 |=> force_zero && lock_pos == $past(act_small))
		else $error("mode 1 lock mismatch");
	rotating_flag_a: assert property ( // RQ7
		aresetn |=> flags.rotating == ($past(act_mag) >= (SPD_W+1)'($past(rot_lim))))
		else $error("rotating flag wrong");
	still_flag_a: assert property ( // RQ9
		aresetn |=> flags.still == ($past(act_mag) < (SPD_W+1)'($past(still_lim))))
		else $error("standstill flag wrong");
	match_flag_a: assert property ( // RQ11
		aresetn |=> flags.match == ($past(diff_mag) <= (SPD_W+1)'($past(match_win))))
		else $error("match flag wrong");
	reached_flag_a: assert property ( // RQ13
		aresetn |=> flags.reached == ($past(act_mag) > (SPD_W+1)'($past(reach_lim))))
		else $error("reached flag wrong");
	limit_range_a: assert property ( // RQ14
		reach_lim >= sszh_pkg::MIN_REACH_LIM && hold_lim <= sszh_pkg::MAX_HOLD_LIM)
		else $error("setting out of range");
	terminal_map_a: assert property ( // RQ15
		do_func[0] == sszh_pkg::FN_ROTATING |=> do_out[0] == flags.rotating)
		else $error("terminal 0 not routed");
	c_lock: cover property (hold_s2 && hold_mode == 2'h2 ##1 lock_pos ##[1:20] !lock_pos);
	c_write: cover property (s_axi_bvalid && s_axi_bresp == sszh_pkg::RESP_OKAY);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_match: cover property (flags.match && flags.rotating);
endmodule

// File: sszh_host_model.sv
`timescale 1ns/100ps
// the host latches the terminals once per clock, as a controller scanning its inputs would
module sszh_host_model #(
	parameter int DO_N = 4
) (
	input  wire logic            aclk,    // system clock
	input  wire logic            aresetn, // synchronous reset, active low
	input  wire logic [DO_N-1:0] do_in,   // terminals from the drive
	output logic      [DO_N-1:0] seen     // last scanned terminal levels
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen <= '0;
		end else begin
			seen <= do_in;
		end
	end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic                  aclk = 1'h0, aresetn = 1'h0, zero_hold_input = 1'h0;
	logic [7:0]            s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]            s_axi_wstrb = 4'hF, do_out, do_seen;
	logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                  s_axi_rvalid, force_zero, lock_pos;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic signed [15:0]    speed_cmd = 16'h0, speed_act = 16'h0;
	sszh_pkg::sszh_flags_t flags;
	logic [31:0]           seed = 32'h15;
	int                    n_mismatch = 0, comparisons = 0;
	localparam logic [1:0] OK = sszh_pkg::RESP_OKAY, ER = sszh_pkg::RESP_SLVERR;

	sszh_top u_sszh_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .zero_hold_input, .speed_cmd, .speed_act,
		.force_zero, .lock_pos, .flags, .do_out);
	sszh_host_model u_sszh_host_model (.aclk, .aresetn, .do_in(do_out), .seen(do_seen));

	initial begin
		forever #12.5 aclk = ~aclk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int mag(int v);
		return (v < 0) ? -v : v;
	endfunction

	// {reached, match, still, rotating}
	function automatic logic [3:0] fexp(int c, int a, int rl, int sl, int mw, int rch);
		return {mag(a) > rch, mag(a - c) <= mw, mag(a) < sl, mag(a) >= rl};
	endfunction

	function automatic logic [3:0] dexp(logic [31:0] fn, logic [3:0] f);
		logic [3:0] r;
		r = 4'h0;
		for (int n = 0; n < 4; n++) begin
			case (fn[8*n +: 8])
				sszh_pkg::FN_ROTATING: r[n] = f[0];
				sszh_pkg::FN_STILL:    r[n] = f[1];
				sszh_pkg::FN_MATCH:    r[n] = f[2];
				sszh_pkg::FN_REACHED:  r[n] = f[3];
				default:               r[n] = 1'h0;
			endcase
		end
		return r;
	endfunction

	// {force_zero, lock_pos}
	function automatic logic [1:0] hexp(int m, logic h, int c, int a, int l);
		case (m)
			0:       return {h, 1'h0};
			1:       return {h, h & (mag(a) < l)};
			2:       return {2{h & (mag(c) < l)}};
			default: return 2'h0;
		endcase
	endfunction

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] rb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int k = 0; k < 60; k++) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			rb = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tb) begin
				s_axi_bready <= 1'h0;
				chk("bresp", {30'h0, er}, {30'h0, rb});
				return;
			end
		end
		chk("write answer", 32'h1, 32'h0);
	endtask

	task automatic axr(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
		logic ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int k = 0; k < 60; k++) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			if (tr) chk("rdata", ed, s_axi_rdata);
			if (tr) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'h0;
			if (tr) begin
				s_axi_rready <= 1'h0;
				return;
			end
		end
		chk("read answer", 32'h1, 32'h0);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		n_mismatch++;
		$display("test watchdog expired");
		report_and_stop();
	end

	initial begin
		int rv[7];
		int rl, sl, mw, rch, hl, c, a, m;
		logic h;
		logic [1:0] ez;
		logic [3:0] ef;
		logic [31:0] dtab[3];
		rv = '{0, 20, 20, 10, 10, 100, 0};
		dtab = '{32'h89888584, 32'h84858889, 32'h00860085};
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 7; i++) axr(8'(4 * i), 32'(rv[i]), OK);
		axr(8'h1C, 32'h06, OK);
		$display("test reset values done");
		axw(8'h04, 32'h3E9, ER);
		axr(8'h04, 32'h14, OK);
		axw(8'h08, 32'h3E9, ER);
		axw(8'h0C, 32'h1771, ER);
		axw(8'h10, 32'h65, ER);
		axw(8'h14, 32'h9, ER);
		axr(8'h14, 32'h64, OK);
		axw(8'h1C, 32'h0, ER);
		axw(8'h20, 32'h0, ER);
		axr(8'h20, 32'h0, ER);
		// partial strobes: only the enabled code byte lands, a limit needs both low lanes
		s_axi_wstrb <= 4'h2;
		axw(8'h18, 32'h89888584, OK);
		axr(8'h18, 32'h00008500, OK);
		s_axi_wstrb <= 4'h1;
		axw(8'h04, 32'h3E8, OK);
		axr(8'h04, 32'h14, OK);
		s_axi_wstrb <= 4'hF;
		$display("test refused accesses done");
		for (int it = 0; it < 48; it++) begin
			rl = int'(rnd() % 1001);
			sl = int'(rnd() % 6001);
			mw = int'(rnd() % 101);
			rch = 10 + int'(rnd() % 5991);
			hl = int'(rnd() % 1001);
			c = int'(rnd() % 3001) - 1500;
			a = int'(rnd() % 3001) - 1500;
			h = 1'(rnd() % 2);
			m = it % 4;
			case (it % 6)
				0: a = hl - 1;
				1: a = rl;
				2: a = -sl;
				3: a = c + mw;
				4: a = rch;
				default: c = -hl;
			endcase
			axw(8'h00, 32'(m), OK);
			axw(8'h04, 32'(hl), OK);
			axw(8'h08, 32'(rl), OK);
			axw(8'h0C, 32'(sl), OK);
			axw(8'h10, 32'(mw), OK);
			axw(8'h14, 32'(rch), OK);
			axw(8'h18, dtab[it % 3], OK);
			@(posedge aclk);
			speed_cmd <= 16'(c);
			speed_act <= 16'(a);
			zero_hold_input <= h;
			// hold pin passes a two-stage synchroniser, so allow five edges
			repeat (5) @(posedge aclk);
			@(negedge aclk);
			ef = fexp(c, a, rl, sl, mw, rch);
			ez = hexp(m, h, c, a, hl);
			chk("flags", {28'h0, ef}, {28'h0, flags});
			chk("terminals", {28'h0, dexp(dtab[it % 3], ef)}, {28'h0, do_seen});
			chk("hold", {30'h0, ez}, {30'h0, force_zero, lock_pos});
			axr(8'h1C, {24'h0, ez, h, 1'h0, ef}, OK);
		end
		$display("test random status and hold done");
		report_and_stop();
	end
endmodule
